// file: rtl/flp_defines.vh
`ifndef FLP_DEFINES_VH
`define FLP_DEFINES_VH

// register byte offsets
`define FLP_OFS_HIGH_TIME 8'h00
`define FLP_OFS_LOW_TIME 8'h04
`define FLP_OFS_CONFIG 8'h08

// configuration field positions
`define FLP_CFG_ENABLE_BIT 0
`define FLP_CFG_SRC_SEL_BIT 1
`define FLP_CFG_INVERT_BIT 2
`define FLP_CFG_PRE_LSB 3
`define FLP_CFG_PRE_MSB 6
`define FLP_CFG_WIDTH 7

// reset values
`define FLP_RST_HIGH_TIME 16'h0000
`define FLP_RST_LOW_TIME 16'hffff
`define FLP_RST_CONFIG 7'h00

// widths
`define FLP_CNT_WIDTH 16
`define FLP_PRE_WIDTH 4

// nominal source clock rates in kHz, for reference by users of the block
`define FLP_FAST_SRC_KHZ 48000
`define FLP_SLOW_SRC_KHZ 100

// holding byte flags: bit 0/1 high-time low/high byte, bit 2/3 low-time bytes
`define FLP_HOLD_ALL 4'hf

`endif

// file: rtl/flp_src_tick.v
`timescale 1ns/1ns
`include "flp_defines.vh"

// source clock synchroniser, select and prescaler; issues one count-enable pulse
module flp_src_tick (
    input wire clock, // system clock, 125 MHz
    input wire resetn, // asynchronous reset, active low
    input wire src_fast, // fast source clock pin, nominally 48 MHz
    input wire src_slow, // slow source clock pin, nominally 100 kHz
    input wire sel_slow, // 1 selects the slow source
    input wire [`FLP_PRE_WIDTH-1:0] prescale, // divide by prescale+1
    input wire run, // counting allowed; low clears the prescaler
    output wire tick // one-cycle count enable
);

    // three-stage synchronisers, one per source
    reg [2:0] fast_sync_ff;
    reg [2:0] slow_sync_ff;
    // filtered levels, updated only when stages two and three agree
    reg fast_lvl_ff;
    reg slow_lvl_ff;
    // prescaler edge counter
    reg [`FLP_PRE_WIDTH-1:0] pre_cnt_ff;
    reg [`FLP_PRE_WIDTH-1:0] nxt_pre_cnt;
    reg tick_ff;
    reg nxt_tick;
    wire fast_rise;
    wire slow_rise;
    wire src_rise;

    // sample both pins; stage one feeds stage two only
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fast_sync_ff <= 3'h0;
            slow_sync_ff <= 3'h0;
        end else begin
            fast_sync_ff <= {fast_sync_ff[1:0], src_fast};
            slow_sync_ff <= {slow_sync_ff[1:0], src_slow};
        end
    end

    // a level change counts once two settled samples agree
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fast_lvl_ff <= 1'b0;
            slow_lvl_ff <= 1'b0;
        end else begin
            if (fast_sync_ff[1] == fast_sync_ff[2]) begin
                fast_lvl_ff <= fast_sync_ff[2];
            end
            if (slow_sync_ff[1] == slow_sync_ff[2]) begin
                slow_lvl_ff <= slow_sync_ff[2];
            end
        end
    end

    // rising edge of each filtered source
    assign fast_rise = fast_sync_ff[1] & fast_sync_ff[2] & ~fast_lvl_ff;
    assign slow_rise = slow_sync_ff[1] & slow_sync_ff[2] & ~slow_lvl_ff;

    assign src_rise = sel_slow ? slow_rise : fast_rise;

    // enable pulse, no clock
    // the counter stays on the system clock, so a source change never glitches it
    always @* begin
        nxt_pre_cnt = pre_cnt_ff;
        nxt_tick = 1'b0;
        if (!run) begin
            // cleared while stopped so each run starts on a whole divide
            nxt_pre_cnt = {`FLP_PRE_WIDTH{1'b0}};
        end else if (src_rise) begin
            if (pre_cnt_ff == prescale) begin
                nxt_pre_cnt = {`FLP_PRE_WIDTH{1'b0}};
                nxt_tick = 1'b1;
            end else begin
                nxt_pre_cnt = pre_cnt_ff + 4'h1;
            end
        end
    end

    // prescaler state
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pre_cnt_ff <= {`FLP_PRE_WIDTH{1'b0}};
            tick_ff <= 1'b0;
        end else begin
            pre_cnt_ff <= nxt_pre_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;

endmodule // flp_src_tick

// file: rtl/flp_pwm.v
// Summary of operation
// - on time lasts high count plus one
// - zero high, nonzero low: output off
// - fast source clock input accepted
// - slow source clock input accepted
// - config picks source and prescale
// - period is prescale plus one times both phases
// - output toggles between on and off
// - sleep clears counters, output off
// - reset restores every default
// - no interrupt from this block
// - high and low time writes land in holding storage
// - transfer after four bytes, off end
// - full on transfers at once
// - transfer empties the holding storage
// - reads return active values only
// - off phase low count plus one; zero is full on
// - config bit two inverts output
// - disable resets counters, output inactive
// - select bit one picks slow clock
`timescale 1ns/1ns
`include "flp_defines.vh"

module flp_pwm #(
    parameter ADDR_W = 8 // register address width
) (
    input wire clock, // system clock, 125 MHz
    input wire resetn, // system wide reset, active low, asynchronous
    input wire [ADDR_W-1:0] reg_addr, // register byte address
    input wire [31:0] reg_wdata, // write data
    input wire [3:0] reg_wbe, // write byte enables
    input wire reg_wr, // write strobe, one cycle
    input wire reg_rd, // read strobe, one cycle
    output wire [31:0] reg_rdata, // read data, valid the cycle after reg_rd
    input wire src_fast, // fast source clock pin
    input wire src_slow, // slow source clock pin
    input wire sleep_req, // sleep request from power clock reset unit
    output wire pulse_pin_out // pulse output to fan or led
);

    // phase machine states, one-hot
    localparam ST_IDLE = 3'b001; // stopped, output inactive
    localparam ST_HIGH = 3'b010; // on phase counting
    localparam ST_LOW = 3'b100; // off phase counting

    // active registers that load the counter
    reg [15:0] high_phase_count_ff;
    reg [15:0] nxt_high_phase_count;
    reg [15:0] low_phase_count_ff;
    reg [15:0] nxt_low_phase_count;
    // configuration
    reg [`FLP_CFG_WIDTH-1:0] config_ff;
    reg [`FLP_CFG_WIDTH-1:0] nxt_config;
    // holding storage and its per-byte written flags
    reg [15:0] hold_high_ff;
    reg [15:0] nxt_hold_high;
    reg [15:0] hold_low_ff;
    reg [15:0] nxt_hold_low;
    reg [3:0] hold_flag_ff;
    reg [3:0] nxt_hold_flag;
    // phase machine
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [`FLP_CNT_WIDTH-1:0] cnt_ff;
    reg [`FLP_CNT_WIDTH-1:0] nxt_cnt;
    // output and read data
    reg pulse_ff;
    reg nxt_pulse;
    reg [31:0] rdata_ff;
    reg [31:0] nxt_rdata;

    wire cfg_enable;
    wire cfg_invert;
    wire cfg_sel_slow;
    wire [`FLP_PRE_WIDTH-1:0] cfg_pre;
    wire run;
    wire tick;
    wire sel_high;
    wire sel_low;
    wire sel_cfg;
    wire [3:0] byte_hit;
    wire hold_full;
    wire full_on;
    wire full_off;
    wire off_end;
    wire xfer;
    wire [15:0] load_high;
    wire [15:0] load_low;

    // configuration fields
    assign cfg_enable = config_ff[`FLP_CFG_ENABLE_BIT];
    assign cfg_sel_slow = config_ff[`FLP_CFG_SRC_SEL_BIT];
    assign cfg_invert = config_ff[`FLP_CFG_INVERT_BIT];
    assign cfg_pre = config_ff[`FLP_CFG_PRE_MSB:`FLP_CFG_PRE_LSB];

    assign run = cfg_enable & ~sleep_req;

    flp_src_tick u_src_tick (
        .clock(clock),
        .resetn(resetn),
        .src_fast(src_fast),
        .src_slow(src_slow),
        .sel_slow(cfg_sel_slow),
        .prescale(cfg_pre),
        .run(run),
        .tick(tick)
    );

    // address decode
    assign sel_high = (reg_addr == `FLP_OFS_HIGH_TIME);
    assign sel_low = (reg_addr == `FLP_OFS_LOW_TIME);
    assign sel_cfg = (reg_addr == `FLP_OFS_CONFIG);

    // bytes of the holding storage touched by this write
    assign byte_hit = {4{reg_wr}} & {sel_low & reg_wbe[1], sel_low & reg_wbe[0],
                                     sel_high & reg_wbe[1], sel_high & reg_wbe[0]};
    assign hold_full = (hold_flag_ff == `FLP_HOLD_ALL);

    // zero low count is full on
    assign full_on = (low_phase_count_ff == 16'h0000);
    assign full_off = (high_phase_count_ff == 16'h0000) & ~full_on;

    // last tick of the off phase
    assign off_end = (state_ff == ST_LOW) & tick & (cnt_ff == 16'h0000);

    // full on transfers at once
    // while stopped no off phase ever ends, so the transfer is immediate
    // leaving full on this way moves the output a few clocks after the write
    assign xfer = hold_full & (off_end | full_on | ~run);

    // value the counter loads for the on phase, new one if a transfer is happening; load_low is unused
    assign load_high = xfer ? hold_high_ff : high_phase_count_ff;
    assign load_low = xfer ? hold_low_ff : low_phase_count_ff;

    // capture into holding storage
    // halfword access is the expected use; byte writes are still tracked
    always @* begin
        nxt_hold_high = hold_high_ff;
        nxt_hold_low = hold_low_ff;
        if (byte_hit[0]) begin
            nxt_hold_high[7:0] = reg_wdata[7:0];
        end
        if (byte_hit[1]) begin
            nxt_hold_high[15:8] = reg_wdata[15:8];
        end
        if (byte_hit[2]) begin
            nxt_hold_low[7:0] = reg_wdata[7:0];
        end
        if (byte_hit[3]) begin
            nxt_hold_low[15:8] = reg_wdata[15:8];
        end
    end

    // transfer empties holding
    // a byte written in the transfer cycle keeps its flag: set wins
    always @* begin
        nxt_hold_flag = (hold_flag_ff & ~{4{xfer}}) | byte_hit;
    end

    // active registers and configuration
    always @* begin
        nxt_high_phase_count = high_phase_count_ff;
        nxt_low_phase_count = low_phase_count_ff;
        nxt_config = config_ff;
        if (xfer) begin
            nxt_high_phase_count = hold_high_ff;
            nxt_low_phase_count = hold_low_ff;
        end
        // config writes take effect directly
        if (reg_wr & sel_cfg & reg_wbe[0]) begin
            nxt_config = reg_wdata[`FLP_CFG_WIDTH-1:0];
        end
    end

    // phase machine and down counter
    always @* begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                // start with the on phase as soon as running
                if (run) begin
                    nxt_state = ST_HIGH;
                    nxt_cnt = load_high;
                end
            end
            ST_HIGH: begin
                if (tick) begin
                    if (cnt_ff == 16'h0000) begin
                        nxt_state = ST_LOW;
                        nxt_cnt = low_phase_count_ff;
                    end else begin
                        nxt_cnt = cnt_ff - 16'h0001;
                    end
                end
            end
            ST_LOW: begin
                if (tick) begin
                    if (cnt_ff == 16'h0000) begin
                        nxt_state = ST_HIGH;
                        nxt_cnt = load_high;
                    end else begin
                        nxt_cnt = cnt_ff - 16'h0001;
                    end
                end
            end
            default: begin
                // illegal code recovers to idle
                nxt_state = ST_IDLE;
                nxt_cnt = 16'h0000;
            end
        endcase
        if (!run) begin
            nxt_state = ST_IDLE;
            nxt_cnt = 16'h0000;
        end
    end

    // output level before inversion is decided by phase and the hold cases
    always @* begin
        nxt_pulse = 1'b0;
        if (nxt_state == ST_IDLE) begin
            nxt_pulse = 1'b0;
        end else if (full_on) begin
            nxt_pulse = 1'b1;
        end else if (full_off) begin
            nxt_pulse = 1'b0;
        end else begin
            nxt_pulse = (nxt_state == ST_HIGH);
        end
    end

    // reads show active values
    // unmapped addresses read as zero
    always @* begin
        nxt_rdata = 32'h00000000;
        if (reg_rd) begin
            if (sel_high) begin
                nxt_rdata = {16'h0000, high_phase_count_ff};
            end else if (sel_low) begin
                nxt_rdata = {16'h0000, low_phase_count_ff};
            end else if (sel_cfg) begin
                nxt_rdata = {25'h0000000, config_ff};
            end
        end
    end

    // every state flop shares one reset process so defaults cannot drift apart
    // reset restores defaults
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            high_phase_count_ff <= `FLP_RST_HIGH_TIME;
            low_phase_count_ff <= `FLP_RST_LOW_TIME;
            config_ff <= `FLP_RST_CONFIG;
            hold_high_ff <= `FLP_RST_HIGH_TIME;
            hold_low_ff <= `FLP_RST_LOW_TIME;
            hold_flag_ff <= 4'h0;
            state_ff <= ST_IDLE;
            cnt_ff <= 16'h0000;
            pulse_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
        end else begin
            high_phase_count_ff <= nxt_high_phase_count;
            low_phase_count_ff <= nxt_low_phase_count;
            config_ff <= nxt_config;
            hold_high_ff <= nxt_hold_high;
            hold_low_ff <= nxt_hold_low;
            hold_flag_ff <= nxt_hold_flag;
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            pulse_ff <= nxt_pulse;
            rdata_ff <= nxt_rdata;
        end
    end

    // polarity select
    // inversion sits after the flop so a polarity write acts next cycle,
    // also while stopped, keeping the idle level truly inactive
    assign pulse_pin_out = pulse_ff ^ cfg_invert;

    // registered read data, zero outside the cycle after a read
    assign reg_rdata = rdata_ff;


endmodule // flp_pwm

// file: testbench/flp_pwm_monitor.sv
`timescale 1ns/1ns
// port-level checker for the pulse generator
module flp_pwm_monitor #(
    parameter ADDR_W = 8 // register address width
) (
    input wire clock, // system clock
    input wire resetn, // reset, active low
    input wire [ADDR_W-1:0] reg_addr, // register address
    input wire [31:0] reg_wdata, // write data
    input wire [3:0] reg_wbe, // byte enables
    input wire reg_wr, // write strobe
    input wire reg_rd, // read strobe
    input wire [31:0] reg_rdata, // read data
    input wire src_fast, // fast source
    input wire src_slow, // slow source
    input wire sleep_req, // sleep request
    input wire pulse_pin_out // pulse output
);
    reg [6:0] cfg_ff; // shadow of the configuration register
    reg src_ff; // last sample of the selected source
    reg [3:0] age_ff; // clocks since that source rose, saturating
    reg [3:0] wr_age_ff; // clocks since the last register write, saturating
    wire src_sel = cfg_ff[1] ? src_slow : src_fast; // selected source
    wire run = cfg_ff[0] && !sleep_req; // counting allowed
    wire mapped = reg_addr == 8'h00 || reg_addr == 8'h04 || reg_addr == 8'h08; // known offset
    // shadow config; the edge age bounds how late the output may react
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cfg_ff <= 7'h00;
            src_ff <= 1'b0;
            age_ff <= 4'hf;
            wr_age_ff <= 4'hf;
        end else begin
            if (reg_wr && reg_wbe[0] && reg_addr == 8'h08)
                cfg_ff <= reg_wdata[6:0];
            src_ff <= src_sel;
            if (src_sel && !src_ff)
                age_ff <= 4'h0;
            else if (age_ff != 4'hf)
                age_ff <= age_ff + 4'h1;
            // a write can end full on at once, without waiting for a source edge
            if (reg_wr) begin
                wr_age_ff <= 4'h0;
            end else if (wr_age_ff != 4'hf) begin
                wr_age_ff <= wr_age_ff + 4'h1;
            end
        end
    end
    default clocking mon_cb @(posedge clock); endclocking
    default disable iff (!resetn);
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero outside a read");
    a_cfg_readback: assert property (
        reg_rd && reg_addr == 8'h08 |=> reg_rdata == {25'h0, $past(cfg_ff)})
        else $error("config read back wrong");
    a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_reserved_zero: assert property (reg_rd |=> reg_rdata[31:16] == 16'h0)
        else $error("reserved bits not zero");
    a_disabled_idle: assert property (
        !cfg_ff[0] [*3] |-> pulse_pin_out == cfg_ff[2])
        else $error("disabled output not inactive");
    a_sleep_off: assert property (sleep_req [*3] |-> pulse_pin_out == cfg_ff[2])
        else $error("sleep output not off");
    a_reset_low: assert property ($rose(resetn) |-> pulse_pin_out == 1'b0)
        else $error("output not low after reset");
    // the output may only move shortly after a source edge, never on its own;
    // leaving full on by a write is paced by the bus instead; a polarity write is not checked
    a_edge_paces_out: assert property (
        run [*5] ##0 (pulse_pin_out != $past(pulse_pin_out) && $stable(cfg_ff[2]))
        |-> age_ff < 4'hc || wr_age_ff < 4'h4)
        else $error("output moved without a source edge");
    c_cfg_read: cover property (reg_rd && reg_addr == 8'h08);
    c_sleep: cover property (cfg_ff[0] && sleep_req);
    c_out_rise: cover property (run && $rose(pulse_pin_out));
endmodule // flp_pwm_monitor

bind flp_pwm flp_pwm_monitor #(.ADDR_W(ADDR_W)) u_mon (.clock(clock), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wbe(reg_wbe), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_fast(src_fast), .src_slow(src_slow),
    .sleep_req(sleep_req), .pulse_pin_out(pulse_pin_out));

// file: testbench/flp_load_model.sv
`timescale 1ns/1ns
// fan or led load: times each stretch of the drive level in whole clocks
module flp_load_model (
    input wire clock, // time base
    input wire resetn, // reset, active low
    input wire drive, // pulse pin from the generator
    output reg [15:0] high_len_ff, // last complete high stretch
    output reg [15:0] low_len_ff, // last complete low stretch
    output reg [15:0] edges_ff // level changes seen
);
    reg level_ff; // level one clock ago
    reg [15:0] run_ff; // clocks at the present level
    // a stretch is stored when it ends, so a partial one never shows
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            level_ff <= 1'b0;
            run_ff <= 16'h0;
            high_len_ff <= 16'h0;
            low_len_ff <= 16'h0;
            edges_ff <= 16'h0;
        end else begin
            level_ff <= drive;
            run_ff <= (drive != level_ff) ? 16'h1 : run_ff + 16'h1;
            if (drive != level_ff) begin
                edges_ff <= edges_ff + 16'h1;
                if (level_ff)
                    high_len_ff <= run_ff;
                else
                    low_len_ff <= run_ff;
            end
        end
    end
endmodule // flp_load_model

// file: testbench/flp_pwm_tb.sv
`timescale 1ns/1ns
// self-checking bench for the pulse generator
module flp_pwm_tb;
    reg clock = 1'b0; // system clock
    reg resetn = 1'b0; // reset, active low
    reg [7:0] reg_addr = 8'h00; // register address
    reg [31:0] reg_wdata = 32'h0; // write data
    reg [3:0] reg_wbe = 4'h0; // byte enables
    reg reg_wr = 1'b0; // write strobe
    reg reg_rd = 1'b0; // read strobe
    reg src_fast = 1'b0; // 25 MHz, slow enough that every edge is seen
    reg src_slow = 1'b0; // 100 kHz
    reg sleep_req = 1'b0; // sleep request
    wire [31:0] reg_rdata; // read data
    wire pulse_pin_out; // pulse output
    wire [15:0] high_len, low_len, edges; // load measurements
    integer n_fail = 0; // mismatches
    integer comparisons = 0; // checks made
    reg [2:0] fast_div = 3'h0; // system clocks within one fast source period
    reg [9:0] slow_div = 10'h000; // system clocks within one slow half period
    always #4 clock = ~clock;
    // sources move right after a rising edge like every other input;
    // the fast one is high two clocks of five so the filter sees each edge
    always @(posedge clock) begin
        fast_div <= (fast_div == 3'h4) ? 3'h0 : fast_div + 3'h1;
        src_fast <= (fast_div < 3'h2);
        slow_div <= (slow_div == 10'h270) ? 10'h000 : slow_div + 10'h001;
        if (slow_div == 10'h270) begin
            src_slow <= ~src_slow;
        end
    end
    flp_pwm dut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wbe(reg_wbe), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .src_fast(src_fast), .src_slow(src_slow), .sleep_req(sleep_req),
        .pulse_pin_out(pulse_pin_out));
    flp_load_model load (.clock(clock), .resetn(resetn), .drive(pulse_pin_out),
        .high_len_ff(high_len), .low_len_ff(low_len), .edges_ff(edges));
    task conclude;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task check(input [31:0] got, input [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // writes with the given byte enables, a gap cycle keeps strobes single-driven
    task wr(input [7:0] a, input [31:0] d, input [3:0] be);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wbe <= be;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        check(reg_rdata, exp);
        @(posedge clock);
    endtask
    task pin(input [31:0] exp, input integer wait_n);
        repeat (wait_n) @(posedge clock);
        @(negedge clock);
        check({31'h0, pulse_pin_out}, exp);
        @(posedge clock);
    endtask
    // four level changes guarantee one whole high and one whole low stretch
    task measure(input [15:0] hi, input [15:0] lo);
        integer i;
        reg [15:0] e0;
        @(negedge clock);
        e0 = edges;
        for (i = 0; i < 20000 && edges - e0 < 16'h4; i++)
            @(negedge clock);
        if (edges - e0 < 16'h4) begin
            n_fail++;
            conclude;
        end else begin
            check(high_len, hi);
            check(low_len, lo);
            @(posedge clock);
        end
    endtask
    task t_reset;
        rd(8'h04, 32'hffff); // low default
        wr(8'h0c, 32'h7f, 4'hf);
        rd(8'h0c, 32'h0); // unmapped
        rd(8'h08, 32'h0); // config default
        rd(8'h00, 32'h0); // high default
        pin(32'h0, 0); // output idle
        $display("reset test done");
    endtask
    task t_period;
        wr(8'h00, 32'h1, 4'h3);
        wr(8'h04, 32'h2, 4'h3);
        wr(8'h08, 32'h1, 4'h1);
        measure(16'ha, 16'hf); // fast phases
        wr(8'h08, 32'h0, 4'h1);
        wr(8'h08, 32'h9, 4'h1);
        measure(16'h14, 16'h1e); // prescale one, divide by two
        $display("period test done");
    endtask
    task t_hold;
        wr(8'h00, 32'h3, 4'h3);
        rd(8'h00, 32'h1); // pending hidden
        measure(16'h14, 16'h1e); // half written
        wr(8'h04, 32'h4, 4'h3);
        measure(16'h28, 16'h32); // all four bytes
        rd(8'h04, 32'h4); // active value
        wr(8'h00, 32'h5, 4'h3);
        wr(8'h04, 32'h1, 4'h1);
        measure(16'h28, 16'h32); // three bytes only
        wr(8'h04, 32'h1, 4'h2);
        measure(16'h3c, 16'h14); // byte wise refill
        $display("holding test done");
    endtask
    task t_full;
        wr(8'h08, 32'h0, 4'h1);
        wr(8'h00, 32'h0, 4'h3);
        wr(8'h04, 32'h3, 4'h3);
        wr(8'h08, 32'h1, 4'h1);
        pin(32'h0, 9); // full off
        pin(32'h0, 13); // full off
        wr(8'h00, 32'h0, 4'h3);
        wr(8'h04, 32'h0, 4'h3);
        pin(32'h1, 40); // full on
        wr(8'h00, 32'h2, 4'h3);
        wr(8'h04, 32'h0, 4'h3);
        rd(8'h00, 32'h2); // immediate transfer
        wr(8'h08, 32'h5, 4'h1);
        pin(32'h0, 2); // inverted on level
        wr(8'h08, 32'h4, 4'h1);
        pin(32'h1, 2); // inactive per polarity
        $display("full and invert test done");
    endtask
    task t_sleep;
        wr(8'h00, 32'h1, 4'h3);
        wr(8'h04, 32'h2, 4'h3);
        wr(8'h08, 32'h1, 4'h1);
        measure(16'ha, 16'hf); // toggling
        sleep_req <= 1'b1;
        pin(32'h0, 2); // sleep forces off
        pin(32'h0, 40); // stays off
        sleep_req <= 1'b0;
        measure(16'ha, 16'hf); // restarts cleanly
        wr(8'h08, 32'h0, 4'h1);
        wr(8'h04, 32'h1, 4'h3);
        wr(8'h00, 32'h1, 4'h3);
        wr(8'h08, 32'h3, 4'h1);
        measure(16'h9c4, 16'h9c4); // slow source
        $display("sleep and slow test done");
    endtask
    initial begin
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        t_reset;
        t_period;
        t_hold;
        t_full;
        t_sleep;
        conclude;
    end
endmodule // flp_pwm_tb
